// ---- src/mac_trx_pkg.sv ----
// Purpose: Constants and types for the transmit status and receive control
//   register block.
// Assumes: One 200 MHz clock; AHB-Lite register access, word aligned.
// Notes: Operation
// Operation
// - Transmit status reports the 6-bit identifier of the frame it describes.
// - Late collision sets the read-only flag at status bit 13.
// - Reaching the collision limit sets the read-only flag at status bit 12.
// - While flush bit 15 is set, clear receive queue and frame pointer.
// - With bit 14 set, UDP frames with bad checksum are discarded.
// - With bit 13 set, TCP frames with bad checksum are discarded.
// - With bit 12 set, IP frames with bad header checksum are discarded.
// - Bit 11 admits unicast frames passing the station filter; resets to one.
// - Full duplex with bit 10 set holds transmit until pause timer expires.
// - Bit 9 set stores CRC error frames; clear discards them all.
// - Bit 8 admits multicast frames passing the filter; others reset zero.
// - Receive runs while bit 0 set; clearing finishes the current frame.
package mac_trx_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_TX_STATUS = 10'h072;
  localparam logic [9:0] IDX_RX_CTRL1 = 10'h074;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h080;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h081;

  // Transmit status fields.
  localparam int TXS_LATE_BIT = 13;
  localparam int TXS_MAX_BIT = 12;
  localparam int TXS_FID_LSB = 0;
  localparam int FID_W = 6;

  // Receive control one fields.
  localparam int RXC_FLUSH = 15;
  localparam int RXC_UDP = 14;
  localparam int RXC_TCP = 13;
  localparam int RXC_IP = 12;
  localparam int RXC_UCAST = 11;
  localparam int RXC_PAUSE = 10;
  localparam int RXC_CRCERR = 9;
  localparam int RXC_MCAST = 8;
  localparam int RXC_ENABLE = 0;
  localparam logic [15:0] RXC_RST = 16'h0800;
  // Bits of this block; receive-control bits 7 to 1 live elsewhere.
  localparam logic [15:0] RXC_OWN_MASK = 16'hff01;

  // Interrupt status and mask bits.
  localparam int IRQ_W = 4;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_TX_COLL = 1;
  localparam int IRQ_RX_DROP = 2;
  localparam int IRQ_PAUSE = 3;

  // One pause quantum is 512 bit times at 100 Mb/s.
  localparam int QUANTUM_NS = 5120;
  localparam int CLK_NS = 5;
  localparam logic [10:0] QUANTUM_CYC =
    11'((QUANTUM_NS + CLK_NS - 1) / CLK_NS);

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_RECV = 3'b010,
    RX_DROP = 3'b100
  } rx_state_t;

  // Completion report of one transmitted frame.
  typedef struct packed {
    logic done;
    logic [FID_W-1:0] frame_id;
    logic late_collision;
    logic max_collision;
  } tx_report_t;

  // Classification of a received frame, valid with its end strobe.
  typedef struct packed {
    logic is_udp;
    logic udp_ok;
    logic is_tcp;
    logic tcp_ok;
    logic is_ip;
    logic ip_ok;
    logic crc_error;
    logic is_unicast;
    logic unicast_match;
    logic is_multicast;
    logic multicast_match;
  } rx_class_t;

  typedef struct packed {
    logic start;
    logic finish;
    rx_class_t cls;
  } rx_frame_t;

  typedef struct packed {
    logic accept;
    logic discard;
  } rx_verdict_t;

endpackage

// ---- src/mac_tx_status_rx_control.sv ----
// Purpose: Transmit status and receive control register logic of the MAC.
// Assumes: All inputs synchronous to hclk; single word AHB-Lite transfers.
// Notes: Zero wait state slave; unmapped addresses read zero, writes ignored.
//
// The AHB-Lite interface to the registers is this design's own decision.
module mac_tx_status_rx_control
  import mac_trx_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Transmit side.
  input wire tx_report_t tx_report,
  output logic tx_hold,
  // Receive side.
  input wire rx_frame_t rx_frame,
  input wire logic full_duplex,
  input wire logic pause_rx,
  input wire logic [15:0] pause_quanta,
  output rx_verdict_t rx_verdict,
  output logic rx_running,
  output logic rx_queue_flush,
  output logic [15:0] rx_frame_ptr,
  // Interrupt.
  output logic irq
);

  typedef struct packed {
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic [15:0] tx_status_reg;
    logic [15:0] rx_control_reg_one;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    rx_state_t rx_state;
    rx_verdict_t verdict;
    logic [15:0] frame_ptr;
    logic [15:0] pause_left;
    logic [10:0] quantum_cnt;
    logic tx_hold;
    logic rx_running;
  } state_t;

  localparam state_t STATE_RST = '{
    wr_pend: 1'b0,
    wr_idx: 10'h000,
    rdata: 32'h0000_0000,
    ready: 1'b1,
    tx_status_reg: 16'h0000,
    rx_control_reg_one: RXC_RST,
    irq_status: '0,
    irq_mask: '0,
    irq: 1'b0,
    rx_state: RX_IDLE,
    verdict: '0,
    frame_ptr: 16'h0000,
    pause_left: 16'h0000,
    quantum_cnt: 11'h000,
    tx_hold: 1'b0,
    rx_running: 1'b0
  };

  state_t s_q;
  state_t s_d;

  logic addr_ok;
  logic [9:0] addr_idx;
  logic frame_bad;
  logic frame_admit;
  logic [IRQ_W-1:0] events;
  logic [15:0] rx_ctl;

  always_comb begin
    s_d = s_q;
    rx_ctl = s_q.rx_control_reg_one;
    events = '0;
    s_d.verdict = '0;
    addr_idx = haddr[11:2];
    addr_ok = hsel && hready &&
              (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // Checksum, CRC and address filter verdict of a finished frame.
    frame_bad = 1'b0;
    if (rx_ctl[RXC_UDP] && rx_frame.cls.is_udp && !rx_frame.cls.udp_ok) begin
      frame_bad = 1'b1;
    end
    if (rx_ctl[RXC_TCP] && rx_frame.cls.is_tcp && !rx_frame.cls.tcp_ok) begin
      frame_bad = 1'b1;
    end
    if (rx_ctl[RXC_IP] && rx_frame.cls.is_ip && !rx_frame.cls.ip_ok) begin
      frame_bad = 1'b1;
    end
    if (!rx_ctl[RXC_CRCERR] && rx_frame.cls.crc_error) begin
      frame_bad = 1'b1;
    end
    frame_admit = 1'b0;
    if (rx_ctl[RXC_UCAST] && rx_frame.cls.is_unicast &&
        rx_frame.cls.unicast_match) begin
      frame_admit = 1'b1;
    end
    if (rx_ctl[RXC_MCAST] && rx_frame.cls.is_multicast &&
        rx_frame.cls.multicast_match) begin
      frame_admit = 1'b1;
    end

    // Receive frame tracking; a frame begun runs to its end.
    case (s_q.rx_state)
      RX_IDLE: begin
        if (rx_frame.start) begin
          if (rx_ctl[RXC_ENABLE] && !rx_ctl[RXC_FLUSH]) begin
            s_d.rx_state = RX_RECV;
          end else begin
            s_d.rx_state = RX_DROP;
          end
        end
      end
      RX_RECV: begin
        if (rx_frame.finish) begin
          s_d.rx_state = RX_IDLE;
          if (frame_admit && !frame_bad) begin
            s_d.verdict.accept = 1'b1;
            s_d.frame_ptr = s_q.frame_ptr + 16'h0001;
          end else begin
            s_d.verdict.discard = 1'b1;
            events[IRQ_RX_DROP] = 1'b1;
          end
        end
      end
      RX_DROP: begin
        if (rx_frame.finish) begin
          s_d.rx_state = RX_IDLE;
        end
      end
      default: begin
        s_d.rx_state = RX_IDLE;
      end
    endcase
    if (rx_ctl[RXC_FLUSH]) begin
      s_d.frame_ptr = 16'h0000;
    end

    // Transmit completion replaces the whole status word.
    if (tx_report.done) begin
      s_d.tx_status_reg = '0;
      s_d.tx_status_reg[TXS_FID_LSB +: FID_W] = tx_report.frame_id;
      s_d.tx_status_reg[TXS_LATE_BIT] = tx_report.late_collision;
      s_d.tx_status_reg[TXS_MAX_BIT] = tx_report.max_collision;
      events[IRQ_TX_DONE] = 1'b1;
      events[IRQ_TX_COLL] = tx_report.late_collision ||
                            tx_report.max_collision;
    end

    // Pause timer, counted in quanta; only in full duplex when enabled.
    if (!rx_ctl[RXC_PAUSE] || !full_duplex) begin
      s_d.pause_left = 16'h0000;
      s_d.quantum_cnt = 11'h000;
    end else if (pause_rx) begin
      s_d.pause_left = pause_quanta;
      s_d.quantum_cnt = 11'h000;
      events[IRQ_PAUSE] = 1'b1;
    end else if (s_q.pause_left != 16'h0000) begin
      if (s_q.quantum_cnt == QUANTUM_CYC - 11'h001) begin
        s_d.quantum_cnt = 11'h000;
        s_d.pause_left = s_q.pause_left - 16'h0001;
      end else begin
        s_d.quantum_cnt = s_q.quantum_cnt + 11'h001;
      end
    end
    s_d.tx_hold = s_d.pause_left != 16'h0000;

    // Register write in the data phase.
    s_d.wr_pend = addr_ok && hwrite;
    s_d.wr_idx = addr_idx;
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        IDX_RX_CTRL1: begin
          s_d.rx_control_reg_one = hwdata[15:0] & RXC_OWN_MASK;
        end
        IDX_IRQ_STATUS: begin
          s_d.irq_status = s_q.irq_status & ~hwdata[IRQ_W-1:0];
        end
        IDX_IRQ_MASK: begin
          s_d.irq_mask = hwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // New events win over a clear in the same cycle.
    s_d.irq_status = s_d.irq_status | events;

    // Read data prepared at the address phase.
    if (addr_ok && !hwrite) begin
      case (addr_idx)
        IDX_TX_STATUS: s_d.rdata = {16'h0000, s_q.tx_status_reg};
        IDX_RX_CTRL1: s_d.rdata = {16'h0000, s_q.rx_control_reg_one};
        IDX_IRQ_STATUS: s_d.rdata = {28'h0000000, s_q.irq_status};
        IDX_IRQ_MASK: s_d.rdata = {28'h0000000, s_q.irq_mask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    s_d.ready = 1'b1;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    s_d.rx_running = s_d.rx_control_reg_one[RXC_ENABLE] ||
                     (s_d.rx_state == RX_RECV);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign tx_hold = s_q.tx_hold;
  assign rx_verdict = s_q.verdict;
  assign rx_running = s_q.rx_running;
  assign rx_queue_flush = s_q.rx_control_reg_one[RXC_FLUSH];
  assign rx_frame_ptr = s_q.frame_ptr;
  assign irq = s_q.irq;

endmodule // mac_tx_status_rx_control

// ---- tb/link_partner.sv ----
// Purpose: Link side model: frames, transmit reports, pause.
// Assumes: Tasks are called just after a rising edge.
// Notes: Idle fields carry inverted values.
module link_partner
  import mac_trx_pkg::*;
(
  // Clock.
  input wire logic hclk,
  // Link side.
  output tx_report_t tx_report,
  output rx_frame_t rx_frame,
  output logic pause_rx,
  output logic [15:0] pause_quanta
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_report = '0;
    rx_frame = '0;
    pause_rx = 1'b0;
    pause_quanta = 16'hffff;
  end
  task automatic frame(input rx_class_t c, input int len);
    rx_frame.start <= 1'b1;
    @(posedge hclk);
    rx_frame.start <= 1'b0;
    repeat (len) @(posedge hclk);
    rx_frame <= '{1'b0, 1'b1, c};
    @(posedge hclk);
    rx_frame <= '{1'b0, 1'b0, ~c};
    @(posedge hclk);
  endtask
  task automatic tx(input logic [5:0] id, input logic lc, mc);
    tx_report <= '{1'b1, id, lc, mc};
    @(posedge hclk);
    tx_report <= '{1'b0, ~id, ~lc, ~mc};
    @(posedge hclk);
  endtask
  task automatic pause(input logic [15:0] q);
    pause_rx <= 1'b1;
    pause_quanta <= q;
    @(posedge hclk);
    pause_rx <= 1'b0;
    pause_quanta <= ~q;
    @(posedge hclk);
  endtask
endmodule // link_partner

// ---- tb/mac_trx_sva.sv ----
// Purpose: Port assertions for the register block.
// Assumes: Bound to the top design module.
// Notes: Sees design ports only.
module mac_trx_sva
  import mac_trx_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Observed ports.
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic full_duplex,
  input wire logic pause_rx,
  input wire logic tx_hold,
  input wire rx_frame_t rx_frame,
  input wire rx_verdict_t rx_verdict,
  input wire logic rx_running,
  input wire logic rx_queue_flush,
  input wire logic [15:0] rx_frame_ptr,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic vd = rx_verdict.accept | rx_verdict.discard;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_flush_ptr: assert property (
    rx_queue_flush && $past(rx_queue_flush) |-> rx_frame_ptr == 16'h0000)
    else $error("frame pointer not held at zero");
  a_ptr_step: assert property (
    rx_frame_ptr != $past(rx_frame_ptr) && !rx_queue_flush |->
    (rx_verdict.accept || $past(rx_verdict.accept)) &&
    rx_frame_ptr == $past(rx_frame_ptr) + 16'h0001)
    else $error("frame pointer moved without accept");
  a_verdict_time: assert property (vd |-> $past(rx_frame.finish))
    else $error("verdict without frame end");
  a_verdict_one: assert property (
    !(rx_verdict.accept && rx_verdict.discard))
    else $error("accept and discard together");
  a_verdict_run: assert property (vd |-> $past(rx_running))
    else $error("verdict while receive stopped");
  a_hold_half: assert property (!full_duplex |=> !tx_hold)
    else $error("hold in half duplex");
  a_hold_cause: assert property (
    $rose(tx_hold) |-> $past(pause_rx) && $past(full_duplex))
    else $error("hold without pause");
  c_accept: cover property (rx_verdict.accept);
  c_discard: cover property (rx_verdict.discard);
  c_hold: cover property ($fell(tx_hold));
  c_irq: cover property ($rose(irq));
endmodule // mac_trx_sva

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the register block.
// Assumes: Zero wait state slave.
// Notes: Reads and verdicts are checked from queues.
module tb
  import mac_trx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_TXS = 32'({IDX_TX_STATUS, 2'b00});
  localparam logic [31:0] A_RXC = 32'({IDX_RX_CTRL1, 2'b00});
  localparam logic [31:0] A_IST = 32'({IDX_IRQ_STATUS, 2'b00});
  localparam logic [31:0] A_IMK = 32'({IDX_IRQ_MASK, 2'b00});
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0, full_duplex = 1'b0, rd_ph = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic hreadyout, hresp, tx_hold, rx_running, rx_queue_flush, irq;
  logic pause_rx;
  logic [15:0] rx_frame_ptr, pause_quanta;
  tx_report_t tx_report;
  rx_frame_t rx_frame;
  rx_verdict_t rx_verdict;
  int errors = 0, num_checks = 0, nacc = 0;
  int seed = 32'hfc38026f;
  logic [31:0] rdq[$];
  logic vdq[$];
  always #2.5 hclk = ~hclk;
  mac_tx_status_rx_control i_mac_tx_status_rx_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_report(tx_report), .tx_hold(tx_hold),
    .rx_frame(rx_frame), .full_duplex(full_duplex), .pause_rx(pause_rx),
    .pause_quanta(pause_quanta), .rx_verdict(rx_verdict),
    .rx_running(rx_running), .rx_queue_flush(rx_queue_flush),
    .rx_frame_ptr(rx_frame_ptr), .irq(irq));
  link_partner i_link_partner (.hclk(hclk), .tx_report(tx_report),
    .rx_frame(rx_frame), .pause_rx(pause_rx), .pause_quanta(pause_quanta));
  task automatic cmp(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    hsize <= 3'b010;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwdata <= ~d;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic ok(input logic [15:0] r, input rx_class_t c);
    ok = ((c.is_unicast & c.unicast_match & r[RXC_UCAST]) |
      (c.is_multicast & c.multicast_match & r[RXC_MCAST])) &
      !(r[RXC_UDP] & c.is_udp & !c.udp_ok) &
      !(r[RXC_TCP] & c.is_tcp & !c.tcp_ok) &
      !(r[RXC_IP] & c.is_ip & !c.ip_ok) & !(!r[RXC_CRCERR] & c.crc_error);
  endfunction
  always @(posedge hclk) begin
    if (rd_ph && hreadyout)
      cmp(hrdata, rdq.pop_front());
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (rx_verdict.accept || rx_verdict.discard)
      cmp({31'h0, rx_verdict.accept}, {31'h0, vdq.pop_front()});
  end
  initial begin
    #100us;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end
  initial begin
    logic [15:0] r;
    rx_class_t c;
    logic [5:0] id;
    logic lc, mc;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_RXC, 32'h0800);
    rd(A_TXS, 32'h0);
    rd(32'h100, 32'h0);
    for (int i = 0; i < 6; i++) begin
      id = 6'($random(seed));
      lc = 1'($random(seed));
      mc = 1'($random(seed));
      i_link_partner.tx(id, lc, mc);
      rd(A_TXS, {18'h0, lc, mc, 6'h0, id});
    end
    for (int i = 0; i < 24; i++) begin
      r = 16'($random(seed)) & 16'h7bff | 16'h0001;
      c = 11'($random(seed));
      bus(1'b1, A_RXC, {16'h0, r});
      rd(A_RXC, {16'h0, r & RXC_OWN_MASK});
      vdq.push_back(ok(r, c));
      nacc += ok(r, c);
      i_link_partner.frame(c, i % 3 + 1);
    end
    bus(1'b1, A_RXC, 32'h0801);
    vdq.push_back(1'b1);
    nacc++;
    fork
      i_link_partner.frame(11'h00c, 8);
      bus(1'b1, A_RXC, 32'h0800);
    join
    i_link_partner.frame(11'h00c, 2);
    cmp(32'(rx_frame_ptr), nacc);
    bus(1'b1, A_RXC, 32'h8800);
    repeat (2) @(posedge hclk);
    cmp({15'h0, rx_queue_flush, rx_frame_ptr}, 32'h00010000);
    bus(1'b1, A_RXC, 32'h0800);
    @(posedge hclk);
    cmp({15'h0, rx_queue_flush, rx_frame_ptr}, 32'h0);
    full_duplex <= 1'b1;
    bus(1'b1, A_RXC, 32'h0c00);
    i_link_partner.pause(16'h0001);
    repeat (1000) @(posedge hclk);
    cmp({31'h0, tx_hold}, 32'h1);
    repeat (40) @(posedge hclk);
    cmp({31'h0, tx_hold}, 32'h0);
    i_link_partner.pause(16'hffff);
    cmp({31'h0, tx_hold}, 32'h1);
    bus(1'b1, A_RXC, 32'h0800);
    full_duplex <= 1'b0;
    repeat (2) @(posedge hclk);
    cmp({31'h0, tx_hold}, 32'h0);
    full_duplex <= 1'b1;
    i_link_partner.pause(16'h0004);
    cmp({31'h0, tx_hold}, 32'h0);
    bus(1'b1, A_IMK, 32'h0);
    bus(1'b1, A_IST, 32'hf);
    i_link_partner.tx(6'h2a, 1'b1, 1'b0);
    rd(A_IST, 32'h3);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, A_IMK, 32'h2);
    repeat (2) @(posedge hclk);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, A_IST, 32'h2);
    repeat (2) @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
    rd(A_IST, 32'h1);
    cmp(vdq.size(), 0);
    final_report();
  end
endmodule // tb
bind mac_tx_status_rx_control mac_trx_sva i_mac_trx_sva (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .full_duplex(full_duplex), .pause_rx(pause_rx), .tx_hold(tx_hold),
  .rx_frame(rx_frame), .rx_verdict(rx_verdict), .rx_running(rx_running),
  .rx_queue_flush(rx_queue_flush), .rx_frame_ptr(rx_frame_ptr),
  .irq(irq));
